/* design/usx_top.v */
// serial channel data path: ahb-lite register slave, transmit buffer and
// shifter hand-off, receive buffer, pin hand-over and interrupt logic
// assumes one ahb-lite master, word accesses, hclk at 100 mhz
`include "usx_defs.vh"
module usx_top #(
  parameter DW = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata_ff,
  output reg hreadyout_ff,
  output reg hresp_ff,
  input wire serial_in_pin,
  input wire sync_clock_pin,
  output reg serial_out_pin_ff,
  output reg serial_out_oe_ff,
  output reg rx_pin_claim_ff,
  output reg irq_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  reg wr_ff;
  reg [7:0] waddr_ff;
  reg [7:0] csb_ff;
  reg [7:0] csc_ff;
  reg [DW-1:0] baud_ff;
  reg [2:0] ist_ff;
  reg [2:0] imsk_ff;
  reg [8:0] txbuf_ff;
  reg txfull_ff;
  reg txon_ff;
  // frame-sent flag, kept until serviced or written with one
  reg txdone_ff;
  reg [8:0] rxbuf_ff;
  reg rxfull_ff;
  reg [2:0] in_s_ff;
  reg in_flt_ff;
  reg [2:0] ck_s_ff;
  reg ck_flt_ff;
  reg ck_prev_ff;
  reg [31:0] rd_val;
  reg [3:0] nbits;
  reg nxt_txdone;
  reg nxt_rxfull;
  reg [2:0] nxt_ist;
  wire tx_line;
  wire tx_busy;
  wire tx_done;
  wire rx_done;
  wire [8:0] rx_data;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite address phase and write decode
  wire acc = hsel & hready & htrans[`USX_HT_ACT];
  wire rd = acc & ~hwrite;
  wire [7:0] raddr = haddr[7:0];
  wire w_data = wr_ff & (waddr_ff == `USX_OFF_DATA);
  wire w_csa = wr_ff & (waddr_ff == `USX_OFF_CSA);
  wire w_csb = wr_ff & (waddr_ff == `USX_OFF_CSB);
  wire w_csc = wr_ff & (waddr_ff == `USX_OFF_CSC);
  wire w_baud = wr_ff & (waddr_ff == `USX_OFF_BAUD);
  wire w_ist = wr_ff & (waddr_ff == `USX_OFF_IST);
  wire w_imsk = wr_ff & (waddr_ff == `USX_OFF_IMSK);
  wire r_data = rd & (raddr == `USX_OFF_DATA);

  // latch the address phase for the write data phase
  // hwdata only stands one cycle later, so the write acts at that edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      waddr_ff <= 8'h00;
    end else begin
      wr_ff <= acc & hwrite;
      waddr_ff <= raddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame format decode
  // size codes four to six are reserved and fall back to eight data bits
  wire [2:0] csz = {csb_ff[`USX_CSB_CSZ2], csc_ff[`USX_CSC_CSZ1], csc_ff[`USX_CSC_CSZ0]};
  wire par_en = csc_ff[`USX_CSC_PHI];
  wire par_odd = csc_ff[`USX_CSC_PLO];
  wire sync_mode = csc_ff[`USX_CSC_SYNC];

  // data bit count from character size
  always @* begin
    if (csz == `USX_CSZ_NINE)
      nbits = `USX_NB_NINE;
    else if (csz[2])
      nbits = `USX_NB_NINE - 4'h1;
    else
      nbits = `USX_NB_BASE + {2'h0, csz[1:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data mux
  // buffer-empty is simply the inverse of the buffer-full register
  wire tx_empty = ~txfull_ff;
  // read value decoded from the address phase, captured into hrdata_ff;
  // the ninth received bit only shows in ctrl_status_b, never in the data word
  always @* begin
    rd_val = 32'h0000_0000;
    case (raddr)
      `USX_OFF_DATA: rd_val[7:0] = rxbuf_ff[7:0];
      `USX_OFF_CSA: begin
        rd_val[`USX_CSA_RXDONE] = rxfull_ff;
        rd_val[`USX_CSA_TXDONE] = txdone_ff;
        rd_val[`USX_CSA_TXEMPTY] = tx_empty;
      end
      `USX_OFF_CSB: begin
        rd_val[7:0] = csb_ff;
        rd_val[`USX_CSB_RX9] = rxbuf_ff[8];
      end
      `USX_OFF_CSC: rd_val[7:0] = csc_ff;
      `USX_OFF_BAUD: rd_val[DW-1:0] = baud_ff;
      `USX_OFF_IST: rd_val[2:0] = ist_ff;
      `USX_OFF_IMSK: rd_val[2:0] = imsk_ff;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // bus answers: zero wait, always okay, read data registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      hrdata_ff <= rd ? rd_val : 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers; buffer-empty bit of csa is read-only
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csb_ff <= `USX_CSB_RST;
      csc_ff <= `USX_CSC_RST;
      baud_ff <= `USX_BAUD_RST;
      imsk_ff <= 3'h0;
    end else begin
      if (w_csb)
        csb_ff <= hwdata[7:0];
      if (w_csc)
        csc_ff <= hwdata[7:0];
      if (w_baud)
        baud_ff <= hwdata[DW-1:0];
      if (w_imsk)
        imsk_ff <= hwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change taken when stages two and three agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_s_ff <= 3'h7;
      in_flt_ff <= 1'b1;
      ck_s_ff <= 3'h0;
      ck_flt_ff <= 1'b0;
      ck_prev_ff <= 1'b0;
    end else begin
      in_s_ff <= {in_s_ff[1:0], serial_in_pin};
      ck_s_ff <= {ck_s_ff[1:0], sync_clock_pin};
      if (in_s_ff[1] == in_s_ff[2])
        in_flt_ff <= in_s_ff[2];
      if (ck_s_ff[1] == ck_s_ff[2])
        ck_flt_ff <= ck_s_ff[2];
      ck_prev_ff <= ck_flt_ff;
    end
  end

  // external clock edges: sample on rise, change on fall
  // clock and data pass equal synchroniser depth, so their phase is kept
  wire ck_rise = ck_flt_ff & ~ck_prev_ff;
  wire ck_fall = ~ck_flt_ff & ck_prev_ff;
  // receiver enable acts at once; an ongoing reception is dropped
  wire rx_en = csb_ff[`USX_CSB_RX_ON];
  wire rx_line = rx_en ? in_flt_ff : 1'b1; // pin goes to receiver

  ////////////////////////////////////////////////////////////////////////////
  // transmit buffer and hand-off to the shifter
  wire tx_load = txfull_ff & txon_ff & ~tx_busy;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txbuf_ff <= 9'h000;
      txfull_ff <= 1'b0;
    end else begin
      if (w_data) begin
        txbuf_ff <= {csb_ff[`USX_CSB_TX9], hwdata[7:0]};
        txfull_ff <= 1'b1; // buffer-empty drops
      end else if (tx_load) begin
        txfull_ff <= 1'b0; // empty again
      end
    end
  end

  // deferred disable: stays on until shifter and buffer are empty
  // a character written just before the disable still goes out whole,
  // and the pin is only handed back once the line rests at idle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txon_ff <= 1'b0;
    end else begin
      if (csb_ff[`USX_CSB_TX_ON])
        txon_ff <= 1'b1;
      else if (!tx_busy && !txfull_ff)
        txon_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit-complete flag: set wins over clear
  // no set while a further character waits: back-to-back frames raise it once
  wire txdone_set = tx_done & ~txfull_ff;
  // clear by writing one to the flag or by servicing its status bit
  wire txdone_clr = (w_csa & hwdata[`USX_CSA_TXDONE]) | (w_ist & hwdata[`USX_IRQ_TXDONE]);
  always @* begin
    nxt_txdone = txdone_set | (txdone_ff & ~txdone_clr);
  end

  // receive buffer full flag: new frame wins over read, disable flushes
  always @* begin
    if (!rx_en)
      nxt_rxfull = 1'b0;
    else
      nxt_rxfull = rx_done | (rxfull_ff & ~r_data);
  end

  // flag and receive buffer registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txdone_ff <= 1'b0;
      rxfull_ff <= 1'b0;
      rxbuf_ff <= 9'h000;
    end else begin
      txdone_ff <= nxt_txdone;
      rxfull_ff <= nxt_rxfull;
      if (rx_done)
        rxbuf_ff <= rx_data; // frame into buffer
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky interrupt status, cleared by writing one; set wins
  // buffer-empty and receive-full are level sources: they set again every
  // cycle while their condition and enable hold, so a clear only sticks
  // once software has refilled or drained the buffer
  // transmit-complete is an edge source: one set per frame that ends with the transmit buffer empty
  wire [2:0] ist_set;
  assign ist_set[`USX_IRQ_TXEMPTY] = tx_empty & csb_ff[`USX_CSB_TXEMPTY_IE];
  assign ist_set[`USX_IRQ_TXDONE] = txdone_set & csb_ff[`USX_CSB_TXDONE_IE];
  assign ist_set[`USX_IRQ_RXDONE] = rxfull_ff & csb_ff[`USX_CSB_RXDONE_IE];
  always @* begin
    nxt_ist = ist_set | (ist_ff & ~({3{w_ist}} & hwdata[2:0]));
  end

  // interrupt line, gated by the mask register
  // built from the next status so the line follows a clear without delay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      ist_ff <= nxt_ist;
      irq_ff <= |(nxt_ist & imsk_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs
  // the line value is registered even while released, so the pin shows
  // idle high the moment the transmitter takes it back
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_out_pin_ff <= 1'b1;
      serial_out_oe_ff <= 1'b0;
      rx_pin_claim_ff <= 1'b0;
    end else begin
      serial_out_pin_ff <= tx_line;
      serial_out_oe_ff <= txon_ff; // released once disabled
      rx_pin_claim_ff <= rx_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shifters
  // both share the divisor and the frame format; a divisor change corrupts a frame on the
  // line, a format change only a frame being received; software must wait for idle
  usx_tx #(
    .DW(DW)
  ) u_tx (
    .clk(hclk),
    .rstn(hresetn),
    .sync_mode(sync_mode),
    .ext_tick(ck_fall),
    .div(baud_ff),
    .load(tx_load),
    .data(txbuf_ff),
    .nbits(nbits),
    .par_en(par_en),
    .par_odd(par_odd),
    .two_stop(csc_ff[`USX_CSC_STOP2]),
    .line_ff(tx_line),
    .busy_ff(tx_busy),
    .done_ff(tx_done)
  );

  // receiver sampled on the external clock in sync mode
  usx_rx #(
    .DW(DW)
  ) u_rx (
    .clk(hclk),
    .rstn(hresetn),
    .en(rx_en),
    .sync_mode(sync_mode),
    .ext_tick(ck_rise),
    .div(baud_ff),
    .line(rx_line),
    .nbits(nbits),
    .par_en(par_en),
    .done_ff(rx_done),
    .data_ff(rx_data)
  );
endmodule

/* design/usx_defs.vh */
// constants of the serial channel: register offsets, field positions, reset values
// assumes inclusion by every design file of the channel; definitions only
// Function
// - buffer-empty flag high while transmit buffer empty, low while it holds data
// - data register write loads transmit buffer and clears buffer-empty flag
// - buffer-empty interrupt requested as long as flag set and enabled
// - transmit-complete flag set when frame shifted out and buffer empty
// - transmit-complete flag cleared on service or by writing one to it
// - transmit-complete interrupt raised when flag becomes set, if enabled
// - parity bit inserted between last data bit and first stop bit
// - transmitter disable waits until shifter and buffer empty, then releases pin
// - receiver enable hands the input pin to the receiver
// - synchronous mode receiver clocks from the external clock pin
// - reception starts on valid start bit, samples each bit at bit rate
// - second stop bit ignored; frame complete at first stop bit
// - completed frame moved into receive buffer, read through data register
// - unused upper data bits read as zero for short characters
// - ninth bit sent as final data bit of the frame
// - shifter takes buffered character when idle or right after last stop
// - transmitter ignores unused upper bits of short characters
`ifndef USX_DEFS_VH
`define USX_DEFS_VH
// register byte offsets
`define USX_OFF_DATA 8'h00
`define USX_OFF_CSA 8'h04
`define USX_OFF_CSB 8'h08
`define USX_OFF_CSC 8'h0c
`define USX_OFF_BAUD 8'h10
`define USX_OFF_IST 8'h14
`define USX_OFF_IMSK 8'h18
// ctrl_status_a fields
`define USX_CSA_RXDONE 7
`define USX_CSA_TXDONE 6
`define USX_CSA_TXEMPTY 5
// ctrl_status_b fields
`define USX_CSB_RXDONE_IE 7
`define USX_CSB_TXDONE_IE 6
`define USX_CSB_TXEMPTY_IE 5
`define USX_CSB_RX_ON 4
`define USX_CSB_TX_ON 3
`define USX_CSB_CSZ2 2
`define USX_CSB_RX9 1
`define USX_CSB_TX9 0
// ctrl_status_c fields
`define USX_CSC_PHI 5
`define USX_CSC_PLO 4
`define USX_CSC_STOP2 3
`define USX_CSC_CSZ1 2
`define USX_CSC_CSZ0 1
`define USX_CSC_SYNC 0
// interrupt status bits
`define USX_IRQ_TXEMPTY 0
`define USX_IRQ_TXDONE 1
`define USX_IRQ_RXDONE 2
// reset values and codes
`define USX_CSB_RST 8'h00
`define USX_CSC_RST 8'h06
`define USX_BAUD_RST 16'h0067
`define USX_CSZ_NINE 3'h7
`define USX_NB_BASE 4'h5
`define USX_NB_NINE 4'h9
`define USX_HT_ACT 1
`endif

/* design/usx_tx.v */
// transmit shifter: builds start, data, parity and stop bits and shifts them out
// assumes load only while busy is low; ext_tick is a one-cycle pulse on hclk
`include "usx_defs.vh"
module usx_tx #(
  parameter DW = 16
) (
  input wire clk,
  input wire rstn,
  input wire sync_mode,
  input wire ext_tick,
  input wire [DW-1:0] div,
  input wire load,
  input wire [8:0] data,
  input wire [3:0] nbits,
  input wire par_en,
  input wire par_odd,
  input wire two_stop,
  output reg line_ff,
  output reg busy_ff,
  output reg done_ff
);
  reg [12:0] sh_ff;
  reg [3:0] left_ff;
  reg [DW-1:0] cnt_ff;
  reg [12:0] frm;
  reg [3:0] flen;
  reg par;
  integer i;
  wire step = sync_mode ? ext_tick : (cnt_ff == div);

  ////////////////////////////////////////////////////////////////////////////
  // frame image, lsb first
  always @* begin
    frm = {13{1'b1}};
    frm[0] = 1'b0;
    par = par_odd;
    for (i = 0; i < 9; i = i + 1) begin
      if (i < nbits) begin // upper bits dropped
        frm[i+1] = data[i]; // ninth bit last
        par = par ^ data[i];
      end
    end
    if (par_en)
      frm[nbits+4'h1] = par;
    flen = nbits + 4'h2 + {3'h0, par_en} + {3'h0, two_stop};
  end

  ////////////////////////////////////////////////////////////////////////////
  // shifting
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_ff <= 13'h1fff;
      left_ff <= 4'h0;
      cnt_ff <= {DW{1'b0}};
      line_ff <= 1'b1;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (load) begin
        sh_ff <= frm;
        left_ff <= flen;
        cnt_ff <= {DW{1'b0}};
        line_ff <= frm[0];
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        cnt_ff <= step ? {DW{1'b0}} : cnt_ff + 1'b1;
        if (step) begin
          sh_ff <= {1'b1, sh_ff[12:1]};
          left_ff <= left_ff - 4'h1;
          line_ff <= sh_ff[1];
          if (left_ff == 4'h1) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
            line_ff <= 1'b1;
          end
        end
      end
    end
  end
endmodule

/* design/usx_rx.v */
// receive shifter: waits for a start bit, samples data, steps over parity unchecked, ends at stop
// assumes line already synchronised and idle high; ext_tick one hclk cycle wide
`include "usx_defs.vh"
module usx_rx #(
  parameter DW = 16
) (
  input wire clk,
  input wire rstn,
  input wire en,
  input wire sync_mode,
  input wire ext_tick,
  input wire [DW-1:0] div,
  input wire line,
  input wire [3:0] nbits,
  input wire par_en,
  output reg done_ff,
  output reg [8:0] data_ff
);
  localparam S_IDLE = 2'h0;
  localparam S_START = 2'h1;
  localparam S_BITS = 2'h2;
  reg [1:0] st_ff;
  reg [3:0] idx_ff;
  reg [DW-1:0] cnt_ff;
  wire step = sync_mode ? ext_tick : (cnt_ff == {DW{1'b0}});
  wire [3:0] total = nbits + {3'h0, par_en};

  ////////////////////////////////////////////////////////////////////////////
  // start detection and bit sampling
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= S_IDLE;
      idx_ff <= 4'h0;
      cnt_ff <= {DW{1'b0}};
      done_ff <= 1'b0;
      data_ff <= 9'h000;
    end else begin
      done_ff <= 1'b0;
      cnt_ff <= step ? div : cnt_ff - 1'b1;
      if (!en) begin
        st_ff <= S_IDLE;
      end else begin
        case (st_ff)
          S_IDLE: begin
            if (!line && (!sync_mode || ext_tick)) begin
              idx_ff <= 4'h0;
              data_ff <= 9'h000; // short chars read zero above
              st_ff <= sync_mode ? S_BITS : S_START;
              cnt_ff <= sync_mode ? div : {1'b0, div[DW-1:1]};
            end
          end
          S_START: begin
            if (step)
              st_ff <= line ? S_IDLE : S_BITS; // valid start only
          end
          S_BITS: begin
            if (step) begin
              if (idx_ff < nbits)
                data_ff[idx_ff] <= line;
              idx_ff <= idx_ff + 4'h1;
              if (idx_ff == total) begin // first stop ends frame
                done_ff <= 1'b1;
                st_ff <= S_IDLE;
              end
            end
          end
          default: st_ff <= S_IDLE;
        endcase
      end
    end
  end
endmodule

/* verification/usx_chk_assertions.sv */
// checker of the channel top: bus answer, bit shape, pin claim, irq mask
// assumes word accesses and BIT_CYC cycles a bit once frames run
module usx_chk #(
  parameter int DW = 16,
  parameter int BIT_CYC = 4
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata_ff,
  input wire hreadyout_ff,
  input wire hresp_ff,
  input wire serial_out_pin_ff,
  input wire serial_out_oe_ff,
  input wire rx_pin_claim_ff,
  input wire irq_ff
);
  localparam int LOW_MAX = 11 * BIT_CYC;
  wire ap = hsel & hready & htrans[1];
  logic csb_wr_ff, msk_wr_ff, claim_exp_ff;
  logic [2:0] msk_ff;
  logic [7:0] low_ff;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////
  // note control and mask writes, count low line cycles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csb_wr_ff <= 1'b0;
      msk_wr_ff <= 1'b0;
      claim_exp_ff <= 1'b0;
      msk_ff <= 3'h0;
      low_ff <= 8'h00;
    end else begin
      csb_wr_ff <= ap && hwrite && haddr[7:0] == 8'h08;
      msk_wr_ff <= ap && hwrite && haddr[7:0] == 8'h18;
      if (csb_wr_ff) claim_exp_ff <= hwdata[4];
      if (msk_wr_ff) msk_ff <= hwdata[2:0];
      low_ff <= serial_out_pin_ff ? 8'h00 : low_ff + {7'h0, low_ff != 8'hff};
    end
  end
  ////////////////////////////////////////////////////////////
  // one bit time is four cycles
  sequence low_bit_s;
    (serial_out_oe_ff && !serial_out_pin_ff) [*4];
  endsequence
  sequence high_bit_s;
    serial_out_pin_ff [*4];
  endsequence
  hready_a: assert property (hreadyout_ff && !hresp_ff)
    else $error("bus stalled or errored");
  rd_idle_a: assert property (!$past(ap && !hwrite) |-> hrdata_ff == 32'h0)
    else $error("read data outside data phase");
  bit_low_a: assert property ($fell(serial_out_pin_ff) |-> low_bit_s)
    else $error("low bit short or pin undriven");
  bit_high_a: assert property ($rose(serial_out_pin_ff) |-> high_bit_s)
    else $error("high bit short");
  frame_len_a: assert property (low_ff <= LOW_MAX)
    else $error("line low too long");
  claim_a: assert property (csb_wr_ff |-> ##2 rx_pin_claim_ff == claim_exp_ff)
    else $error("input pin claim wrong");
  irq_mask_a: assert property ((msk_ff == 3'h0) [*3] |-> !irq_ff)
    else $error("irq while fully masked");
  data_hi_a: assert property (hrdata_ff[31:16] == 16'h0)
    else $error("upper read bits set");
endmodule

/* verification/usx_far_end.sv */
// remote serial partner: decodes frames from the channel, sends queued frames
// decoder assumes asynchronous mode and a bit time of bit_cyc hclk cycles; sends with sync_on take twice that a bit
module usx_far_end (
  input wire clk,
  input wire tx_line,
  output logic rx_line,
  output logic sync_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_cyc = 4;
  int nbits = 8;
  int par_en = 0;
  int par_odd = 0;
  int sync_on = 0;
  int got_q[$];
  int out_q[$];
  ////////////////////////////////////////////////////////////
  // start, data lsb first, parity, one stop bit
  task automatic send(input int v);
    int i;
    v = v & ((1 << nbits) - 1);
    if (par_en != 0) v = v | ((($countones(v) & 1) ^ par_odd) << nbits);
    v = (v << 1) | (1 << (nbits + par_en + 1));
    for (i = 0; i < nbits + par_en + 2; i++) begin
      rx_line <= v[i];
      // sync mode: clock falls with the data change, rises mid-bit
      if (sync_on != 0) begin
        sync_clk <= 1'b0;
        repeat (bit_cyc) @(posedge clk);
        sync_clk <= 1'b1;
      end
      repeat (bit_cyc) @(posedge clk);
    end
  endtask
  // idle line high, external clock still
  initial begin
    rx_line = 1'b1;
    sync_clk = 1'b0;
  end
  // frames back to back while queued
  initial forever begin
    @(posedge clk);
    if (out_q.size() > 0) send(out_q.pop_front());
  end
  // decoder samples each bit mid-way
  initial forever begin
    int v;
    int i;
    @(negedge tx_line);
    repeat (bit_cyc / 2) @(posedge clk);
    if (tx_line === 1'b0) begin
      v = 0;
      for (i = 0; i < nbits + par_en; i++) begin
        repeat (bit_cyc) @(posedge clk);
        v = v | (int'(tx_line) << i);
      end
      repeat (bit_cyc) @(posedge clk);
      got_q.push_back(tx_line === 1'b1 ? v : -1);
    end
  end
endmodule

/* verification/tb_top.sv */
// bench of the serial channel: ahb-lite master tasks, frame model, verdict
// assumes the far-end model on the pins and a divisor of 3 (4 cycles a bit)
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, n9;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rd, d;
  wire [31:0] hrdata_ff;
  wire hreadyout_ff, hresp_ff, serial_in_pin, sync_clock_pin;
  wire serial_out_pin_ff, serial_out_oe_ff, rx_pin_claim_ff, irq_ff;
  int failures = 0;
  int checks = 0;
  int exp_q[$];
  int rx_q[$];
  int zt[5] = '{3, 0, 2, 7, 1};
  int pt[5] = '{0, 1, 1, 1, 0};
  int ot[5] = '{0, 0, 1, 1, 0};
  int c, i, nb;
  usx_top #(.DW(16)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout_ff),
    .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
    .serial_in_pin(serial_in_pin), .sync_clock_pin(sync_clock_pin),
    .serial_out_pin_ff(serial_out_pin_ff), .serial_out_oe_ff(serial_out_oe_ff),
    .rx_pin_claim_ff(rx_pin_claim_ff), .irq_ff(irq_ff));
  usx_far_end u_far (.clk(hclk), .tx_line(serial_out_pin_ff), .rx_line(serial_in_pin),
    .sync_clk(sync_clock_pin));
  ////////////////////////////////////////////////////////////
  // clock, 10 ns period
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // compare, verdict, hang cut
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic hang();
    failures++;
    give_verdict();
  endtask
  // bus master: hold each phase until hready
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 100) hang();
    end while (hreadyout_ff !== 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    wait_rdy();
    rd = hrdata_ff;
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 0);
      n++;
      if (n > 500) hang();
    end while (rd[b] !== v);
  endtask
  // frame model and format setup
  function automatic int fr_model(input int v, input int n, input int pe, input int po);
    v = v & ((1 << n) - 1);
    return pe != 0 ? v | ((($countones(v) & 1) ^ po) << n) : v;
  endfunction
  task automatic cfg(input int z, input int pe, input int po);
    bus(1'b1, 8'h0c, {26'h0, pe[0], po[0], 1'b1, z[1:0], 1'b0});
    u_far.nbits = z < 4 ? z + 5 : (z == 7 ? 9 : 8);
    u_far.par_en = pe;
    u_far.par_odd = po;
  endtask
  task automatic tx_check();
    int n;
    n = 0;
    while (exp_q.size() > 0) begin
      @(posedge hclk);
      n++;
      if (n > 3000) hang();
      if (u_far.got_q.size() > 0) chk(u_far.got_q.pop_front(), exp_q.pop_front());
    end
  endtask
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    void'($urandom(32'h8698));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h0c, 0);
    chk(rd, 32'h6);
    bus(1'b0, 8'h10, 0);
    chk(rd, 32'h67);
    bus(1'b0, 8'h04, 0);
    chk(rd, 32'h20);
    bus(1'b0, 8'h1c, 0);
    chk(rd, 32'h0);
    $display("test reset done");
    bus(1'b1, 8'h10, 32'h3);
    for (c = 0; c < 5; c++) begin
      cfg(zt[c], pt[c], ot[c]);
      nb = u_far.nbits;
      for (i = 0; i < 3; i++) begin
        if (i == 2) poll(8'h04, 5, 1'b1);
        n9 = 1'($urandom);
        bus(1'b1, 8'h08, {29'h3, zt[c] > 3, 1'b0, n9});
        d = $urandom;
        bus(1'b1, 8'h00, d);
        exp_q.push_back(fr_model(zt[c] == 7 ? {23'h0, n9, d[7:0]} : d, nb, pt[c], ot[c]));
        if (i == 1) begin
          bus(1'b0, 8'h04, 0);
          chk(rd[5], 1'b0);
        end
      end
      tx_check();
      poll(8'h04, 6, 1'b1);
      bus(1'b1, 8'h04, 32'h40);
      bus(1'b0, 8'h04, 0);
      chk(rd[6], 1'b0);
      repeat (2) begin
        rx_q.push_back($urandom);
        u_far.out_q.push_back(rx_q[$]);
      end
      repeat (2) begin
        poll(8'h04, 7, 1'b1);
        bus(1'b0, 8'h00, 0);
        chk(rd, rx_q.pop_front() & ((1 << nb) - 1) & 255);
      end
      $display("test format %0d done", c);
    end
    bus(1'b1, 8'h14, 32'h7);
    bus(1'b1, 8'h08, 32'h78);
    repeat (3) @(posedge hclk);
    chk(irq_ff, 1'b0);
    bus(1'b1, 8'h18, 32'h1);
    repeat (3) @(posedge hclk);
    chk(irq_ff, 1'b1);
    bus(1'b1, 8'h18, 32'h2);
    bus(1'b1, 8'h14, 32'h7);
    d = $urandom;
    bus(1'b1, 8'h00, d);
    exp_q.push_back(fr_model(d, nb, 0, 0));
    chk(irq_ff, 1'b0);
    tx_check();
    poll(8'h04, 6, 1'b1);
    repeat (3) @(posedge hclk);
    chk(irq_ff, 1'b1);
    bus(1'b1, 8'h14, 32'h2);
    bus(1'b0, 8'h04, 0);
    chk(rd[6], 1'b0);
    chk(irq_ff, 1'b0);
    $display("test irq done");
    d = $urandom;
    bus(1'b1, 8'h00, d);
    exp_q.push_back(fr_model(d, nb, 0, 0));
    bus(1'b1, 8'h08, 32'h10);
    chk(serial_out_oe_ff, 1'b1);
    chk(rx_pin_claim_ff, 1'b1);
    tx_check();
    repeat (16) @(posedge hclk);
    chk(serial_out_oe_ff, 1'b0);
    bus(1'b1, 8'h08, 32'h0);
    repeat (3) @(posedge hclk);
    chk(rx_pin_claim_ff, 1'b0);
    $display("test disable done");
    // receive on the external clock: 8 data bits, no parity
    bus(1'b1, 8'h08, 32'h10);
    bus(1'b1, 8'h0c, 32'h7);
    u_far.nbits = 8;
    u_far.par_en = 0;
    u_far.sync_on = 1;
    rx_q.push_back($urandom);
    u_far.out_q.push_back(rx_q[$]);
    poll(8'h04, 7, 1'b1);
    bus(1'b0, 8'h00, 0);
    chk(rd, rx_q.pop_front() & 255);
    $display("test sync done");
    give_verdict();
  end
endmodule

bind usx_top usx_chk #(.DW(DW), .BIT_CYC(4)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff),
  .hresp_ff(hresp_ff), .serial_out_pin_ff(serial_out_pin_ff),
  .serial_out_oe_ff(serial_out_oe_ff), .rx_pin_claim_ff(rx_pin_claim_ff), .irq_ff(irq_ff));
